/* inc/wdrr_pkg.sv */
`default_nettype none
package wdrr_pkg;
  // Register word addresses on the plain register port
  localparam logic [3:0] ADDR_PWR_EN = 4'h0;
  localparam logic [3:0] ADDR_RELOAD = 4'h1;
  localparam logic [3:0] ADDR_ARM = 4'h2;
  localparam logic [3:0] ADDR_START = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_IRQ_CLR = 4'h5;
  localparam logic [3:0] ADDR_IRQ_EN = 4'h6;
  localparam logic [3:0] ADDR_COUNT_LO = 4'h7;
  localparam logic [3:0] ADDR_COUNT_HI = 4'h8;
  // Field positions
  localparam int WDOG_EN_POS = 6;
  localparam int REFRESH_BIT_POS = 6;
  localparam int PRESCALE_SELECT_POS = 7;
  localparam int OVF_POS = 0;
  // Reset values and terminal count
  localparam logic [7:0] RELOAD_RST = 8'h00;
  localparam logic [7:0] PWR_EN_RST = 8'h00;
  localparam logic [14:0] COUNT_RST = 15'h0000;
  localparam logic [14:0] COUNT_TERM = 15'h7FFF;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  // Prescaler ratios, in oscillator cycles per count
  localparam int PRESC_SLOW_OFF = 24;
  localparam int PRESC_SLOW_ON = 384;
  localparam logic [8:0] DIV_FAST_MAX = 9'(PRESC_SLOW_OFF - 1);
  localparam logic [8:0] DIV_SLOW_MAX = 9'(PRESC_SLOW_ON - 1);
  // Length of the processor reset pulse, in clock cycles
  localparam logic [3:0] CPU_RST_CYCLES = 4'h8;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } wdrr_bus_req_t;
endpackage
`default_nettype wire

/* hdl/wdrr_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none
module wdrr_prescaler
  import wdrr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Control
  input wire logic run,
  input wire logic slow,
  input wire logic restart,
  // Tick out
  output logic tick
);
  logic [8:0] cnt_q;
  logic [8:0] cnt_d;
  logic [8:0] max_v;

  always_comb
  begin
    max_v = slow ? DIV_SLOW_MAX : DIV_FAST_MAX; // see RQ2 see RQ8
    cnt_d = cnt_q;
    tick = 1'b0;
    if (!run || restart)
    begin
      cnt_d = 9'h000;
    end
    else if (cnt_q >= max_v)
    begin
      cnt_d = 9'h000;
      tick = 1'b1; // see RQ8
    end
    else
    begin
      cnt_d = cnt_q + 9'h001;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      cnt_q <= 9'h000;
    else
      cnt_q <= cnt_d;
  end
endmodule
`default_nettype wire

/* hdl/wdrr_top.sv */
// How it works
// RQ1 - Software sets the enable bit in the peripheral power enable register before counting starts.
// RQ2 - Bit 7 of the reload register picks the slow or fast prescaler.
// RQ3 - The low seven reload bits give the upper seven bits of the 15-bit counter.
// RQ4 - Only an arm write followed at once by a start write refreshes or starts the counter.
// RQ5 - A missed refresh lets the counter expire and the processor is reset.
// RQ6 - The watchdog restart sends the processor to the normal reset address, zero.
// RQ7 - Software should mask interrupts around the two refresh writes.
// RQ8 - The counter steps every 24 cycles, or every 384 with the prescaler bit set.
// RQ9 - Reaching all ones raises the overflow that causes the reset.
// RQ10 - Each overflow sets a sticky status flag that software clears and reset clears.
// RQ11 - Each valid refresh loads the reload value into the counter's high part.
// RQ12 - With the enable bit clear the counter halts and nothing fires.
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module wdrr_top
  import wdrr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Processor reset
  output logic cpu_reset,
  output logic [15:0] cpu_reset_vector,
  // Interrupt
  output logic irq
);
  wdrr_bus_req_t req;
  logic [7:0] pwr_en_q, pwr_en_d;
  logic [7:0] reload_q, reload_d;
  logic armed_q, armed_d;
  logic started_q, started_d;
  logic [14:0] count_q, count_d;
  logic ovf_q, ovf_d;
  logic irq_en_q, irq_en_d;
  logic [3:0] rst_cnt_q, rst_cnt_d;
  logic [7:0] rdata_q, rdata_d;
  logic tick;
  logic enabled;
  logic arm_wr;
  logic start_wr;
  logic refresh;
  logic overflow;

  // Write of a refresh bit to one of the two refresh addresses
  function automatic logic refresh_bit_wr(input wdrr_bus_req_t r, input logic [3:0] a);
    return r.wr && r.addr == a && r.wdata[REFRESH_BIT_POS];
  endfunction

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign enabled = pwr_en_q[WDOG_EN_POS]; // see RQ1 see RQ12
  assign arm_wr = refresh_bit_wr(req, ADDR_ARM);
  assign start_wr = refresh_bit_wr(req, ADDR_START);
  // Armed lasts only one cycle, so any other access in between kills it
  // Expiry beats a start that lands in the terminal cycle
  assign refresh = start_wr && armed_q && enabled && !overflow; // see RQ4
  assign overflow = enabled && started_q && count_q == COUNT_TERM; // see RQ9 see RQ12

  wdrr_prescaler u_wdrr_prescaler (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .run(enabled && started_q),
    .slow(reload_q[PRESCALE_SELECT_POS]),
    .restart(refresh),
    .tick(tick)
  );

  always_comb
  begin
    pwr_en_d = pwr_en_q;
    reload_d = reload_q;
    irq_en_d = irq_en_q;
    armed_d = arm_wr; // see RQ4
    started_d = started_q;
    count_d = count_q;
    ovf_d = ovf_q;
    rst_cnt_d = rst_cnt_q;
    // Countdown first so a fresh expiry always restarts the full pulse
    if (rst_cnt_q != 4'h0)
      rst_cnt_d = rst_cnt_q - 4'h1;
    if (req.wr)
    begin
      case (req.addr)
        ADDR_PWR_EN: pwr_en_d = req.wdata;
        ADDR_RELOAD: reload_d = req.wdata;
        ADDR_IRQ_EN: irq_en_d = req.wdata[OVF_POS];
        ADDR_IRQ_CLR:
        begin
          if (req.wdata[OVF_POS])
            ovf_d = 1'b0; // see RQ10
        end
        default: ;
      endcase
    end
    if (refresh)
    begin
      started_d = 1'b1;
      count_d = {reload_q[6:0], 8'h00}; // see RQ3 see RQ11
    end
    else if (overflow)
    begin
      // Expiry resets the processor and leaves the watchdog stopped
      started_d = 1'b0;
      count_d = COUNT_RST;
      rst_cnt_d = CPU_RST_CYCLES; // see RQ5
    end
    else if (tick)
    begin
      count_d = count_q + 15'h0001; // see RQ8
    end
    if (overflow)
      ovf_d = 1'b1; // see RQ10
  end

  always_comb
  begin
    rdata_d = 8'h00;
    if (req.rd)
    begin
      case (req.addr)
        ADDR_PWR_EN: rdata_d = pwr_en_q;
        ADDR_RELOAD: rdata_d = reload_q;
        ADDR_STATUS: rdata_d = {7'h00, ovf_q};
        ADDR_IRQ_EN: rdata_d = {7'h00, irq_en_q};
        ADDR_COUNT_LO: rdata_d = count_q[7:0];
        ADDR_COUNT_HI: rdata_d = {1'b0, count_q[14:8]};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      pwr_en_q <= PWR_EN_RST;
      reload_q <= RELOAD_RST;
      irq_en_q <= 1'b0;
      armed_q <= 1'b0;
      started_q <= 1'b0;
      count_q <= COUNT_RST;
      ovf_q <= 1'b0;
      rst_cnt_q <= 4'h0;
      rdata_q <= 8'h00;
    end
    else
    begin
      pwr_en_q <= pwr_en_d;
      reload_q <= reload_d;
      irq_en_q <= irq_en_d;
      armed_q <= armed_d;
      started_q <= started_d;
      count_q <= count_d;
      ovf_q <= ovf_d;
      rst_cnt_q <= rst_cnt_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign cpu_reset = rst_cnt_q != 4'h0;
  assign cpu_reset_vector = RESET_VECTOR; // see RQ6
  assign irq = ovf_q && irq_en_q;

  AST_REFRESH_LOAD: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RQ11
    refresh |=> count_q == {$past(reload_q[6:0]), 8'h00})
    else $error("refresh did not load reload value");
  AST_NO_LONE_START: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RQ4
    (start_wr && !$past(arm_wr) && !started_q) |=> !started_q)
    else $error("start without arm took effect");
  AST_RESET_ON_OVF: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RQ5
    overflow |=> cpu_reset [*8] ##1 !cpu_reset)
    else $error("processor reset pulse wrong");
  AST_OVF_FLAG: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RQ10
    overflow |=> ovf_q)
    else $error("overflow flag not set");
  AST_FLAG_STICKY: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RQ10
    (ovf_q && !(req.wr && req.addr == ADDR_IRQ_CLR)) |=> ovf_q)
    else $error("overflow flag lost");
  AST_HALT: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RQ12
    (!enabled && !refresh) |=> $stable(count_q))
    else $error("counter moved while disabled");
  AST_OVF_TERM: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RQ9
    (enabled && started_q && count_q == COUNT_TERM && !refresh) |=> count_q == COUNT_RST)
    else $error("terminal state did not overflow");
  AST_FAST_STEP: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RQ8
    (tick && !reload_q[PRESCALE_SELECT_POS]) |=> !tick [*8])
    else $error("prescaler ticks too often");
  AST_VECTOR: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RQ6
    cpu_reset |-> cpu_reset_vector == 16'h0000)
    else $error("reset vector not zero");
endmodule
`default_nettype wire

/* testbench/wdrr_sw_model.sv */
`timescale 1ns/1ps
`default_nettype none
module wdrr_sw_model
  import wdrr_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Register port
  output logic [3:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  initial
  begin
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // One-cycle write; strobe dropped only by the next call or idle
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
  endtask
  task automatic idle();
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] q);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    q = reg_rdata;
  endtask
  // Power enable bit must be set first
  task automatic enable(input logic on);
    wr(ADDR_PWR_EN, on ? 8'h40 : 8'h00);
    idle();
  endtask
  // Back to back, as if interrupts were masked
  task automatic refresh();
    wr(ADDR_ARM, 8'h40);
    wr(ADDR_START, 8'h40);
    idle();
  endtask
endmodule
`default_nettype wire

/* testbench/watchdog_refresh_reset_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module watchdog_refresh_reset_tb
  import wdrr_pkg::*;
;
  logic clk_sys, rst_n, reg_wr, reg_rd, cpu_reset, irq;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, q, rel;
  logic [15:0] cpu_reset_vector;
  int mismatches, compares, seed, n;
  wdrr_top u_wdrr_top(.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cpu_reset(cpu_reset), .cpu_reset_vector(cpu_reset_vector), .irq(irq));
  wdrr_sw_model u_wdrr_sw_model(.clk_sys(clk_sys), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rchk(input string name, input logic [3:0] a, input logic [7:0] exp);
    u_wdrr_sw_model.rd(a, q);
    chk(name, {8'h00, q}, {8'h00, exp});
  endtask
  task automatic end_of_test();
    if (mismatches == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Sampled mid-step, so off-by-a-few cycles in tick phase is tolerated
  function automatic logic [7:0] ticks(input int cyc, input int div);
    return 8'(cyc / div);
  endfunction
  task automatic settle();
    @(posedge clk_sys);
    #1;
  endtask
  initial
  begin
    #400000;
    mismatches++;
    end_of_test();
  end
  initial
  begin
    seed = 86;
    rst_n = 1'b0;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    rchk("reload", ADDR_RELOAD, RELOAD_RST);
    rchk("status", ADDR_STATUS, 8'h00);
    rchk("unmapped", 4'hF, 8'h00);
    u_wdrr_sw_model.wr(ADDR_RELOAD, 8'h7F);
    u_wdrr_sw_model.refresh();
    repeat (40) @(posedge clk_sys);
    rchk("halted", ADDR_COUNT_HI, 8'h00);
    u_wdrr_sw_model.enable(1'b1);
    rchk("power back", ADDR_PWR_EN, 8'h40);
    u_wdrr_sw_model.wr(ADDR_ARM, 8'h40);
    u_wdrr_sw_model.idle();
    u_wdrr_sw_model.wr(ADDR_START, 8'h40);
    u_wdrr_sw_model.idle();
    rchk("gap refresh", ADDR_COUNT_HI, 8'h00);
    rchk("reload back", ADDR_RELOAD, 8'h7F);
    u_wdrr_sw_model.refresh();
    repeat (126) @(posedge clk_sys);
    rchk("fast ticks", ADDR_COUNT_LO, ticks(128, PRESC_SLOW_OFF));
    rchk("high load", ADDR_COUNT_HI, 8'h7F);
    n = 0;
    while (cpu_reset !== 1'b1 && n < 9000)
    begin
      settle();
      n++;
    end
    chk("expired", {15'h0000, cpu_reset}, 16'h0001);
    n = 0;
    while (cpu_reset === 1'b1 && n < 20)
    begin
      settle();
      n++;
    end
    chk("reset length", 16'(n), 16'(CPU_RST_CYCLES));
    chk("vector", cpu_reset_vector, 16'h0000);
    rchk("ovf flag", ADDR_STATUS, 8'h01);
    chk("irq masked", {15'h0000, irq}, 16'h0000);
    u_wdrr_sw_model.wr(ADDR_IRQ_EN, 8'h01);
    u_wdrr_sw_model.idle();
    settle();
    chk("irq on", {15'h0000, irq}, 16'h0001);
    u_wdrr_sw_model.wr(ADDR_IRQ_CLR, 8'h01);
    u_wdrr_sw_model.idle();
    settle();
    chk("irq off", {15'h0000, irq}, 16'h0000);
    rchk("ovf clear", ADDR_STATUS, 8'h00);
    rel = 8'h80 | (8'($random(seed)) & 8'h7F);
    u_wdrr_sw_model.wr(ADDR_RELOAD, rel);
    u_wdrr_sw_model.refresh();
    repeat (954) @(posedge clk_sys);
    rchk("slow ticks", ADDR_COUNT_LO, ticks(958, PRESC_SLOW_ON));
    rchk("slow high", ADDR_COUNT_HI, {1'b0, rel[6:0]});
    // Second expiry, then a reset that lands inside the processor reset pulse
    u_wdrr_sw_model.wr(ADDR_RELOAD, 8'h7F);
    u_wdrr_sw_model.refresh();
    n = 0;
    while (cpu_reset !== 1'b1 && n < 7000)
    begin
      settle();
      n++;
    end
    chk("second expiry", {15'h0000, cpu_reset}, 16'h0001);
    chk("irq again", {15'h0000, irq}, 16'h0001);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    settle();
    chk("pulse after reset", {15'h0000, cpu_reset}, 16'h0000);
    chk("irq after reset", {15'h0000, irq}, 16'h0000);
    rchk("flag after reset", ADDR_STATUS, 8'h00);
    rchk("power after reset", ADDR_PWR_EN, PWR_EN_RST);
    end_of_test();
  end
endmodule
`default_nettype wire
